/* File: timer_pkg.sv */
// Constants, register map and types of the dual timer/counter.
// Assumes one 8-bit register port, one clock and an active-low reset.
package timer_pkg;

	// Register port
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam logic [ADDR_W-1:0] OFS_MODE = 3'h0;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 3'h1;
	localparam logic [ADDR_W-1:0] OFS_LOW0 = 3'h2;
	localparam logic [ADDR_W-1:0] OFS_HIGH0 = 3'h3;
	localparam logic [ADDR_W-1:0] OFS_LOW1 = 3'h4;
	localparam logic [ADDR_W-1:0] OFS_HIGH1 = 3'h5;
	localparam logic [ADDR_W-1:0] OFS_PORTMODE = 3'h6;

	// Control register fields
	localparam int CTRL_OVF1_BIT = 7;
	localparam int CTRL_RUN1_BIT = 6;
	localparam int CTRL_OVF0_BIT = 5;
	localparam int CTRL_RUN0_BIT = 4;

	// Port mode register fields
	localparam int PM_TOGGLE0_BIT = 0;
	localparam int PM_TOGGLE1_BIT = 1;

	// Mode register: timer 1 nibble high, timer 0 nibble low
	localparam int NIBBLE_W = 4;
	localparam int MODE_T1_LSB = 4;
	localparam int MODE_T0_LSB = 0;

	// Thirteen-bit mode uses the low five bits of the low byte
	localparam int LOW13_BITS = 5;

	// Timing: one machine cycle is six CPU clocks
	localparam int MACHINE_CLOCKS = 6;
	localparam int PRESCALE_W = 3;
	localparam logic [PRESCALE_W-1:0] PRESCALE_LAST =
		PRESCALE_W'(MACHINE_CLOCKS - 1);

	localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;

	typedef enum logic [1:0] {
		MODE13 = 2'b00,
		MODE16 = 2'b01,
		RELOAD8 = 2'b10,
		SPLIT8 = 2'b11
	} mode_t;

	typedef struct packed {
		logic gate;
		logic counterSel;
		mode_t mode;
	} modeNibble_t;

	typedef struct packed {
		logic ovf;
		logic [DATA_W-1:0] low;
		logic [DATA_W-1:0] high;
	} stepResult_t;

endpackage : timer_pkg

/* File: dual_timer_counter_toggle.sv */
// Two timer/counters with gating, overflow flags and toggle outputs.
// Assumes count and gate pins are synchronous to sys_clk; the count pins
// are two-way, driven only while their toggle output is enabled.
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module dual_timer_counter_toggle
	import timer_pkg::*;
(
	input wire logic sys_clk, // 40 MHz CPU clock
	input wire logic reset_n, // Asynchronous reset
	input wire logic [ADDR_W-1:0] regAddr, // Register address
	input wire logic [DATA_W-1:0] regWdata, // Write data
	input wire logic regWr, // Write strobe
	input wire logic regRd, // Read strobe
	output logic [DATA_W-1:0] regRdata, // Read data, cycle after strobe
	input wire logic [1:0] countPinIn, // Count pin levels
	output logic [1:0] countPinOut, // Toggle output levels
	output logic [1:0] countPinOeN, // Low while pin is driven
	input wire logic [1:0] gatePin, // External gate pins
	input wire logic [1:0] overflowServiced, // Interrupt service pulses
	output logic [1:0] overflowFlag, // Overflow flags
	output logic baudTick // Timer 1 overflow pulse
);

	////////////////////////////////////////////////////////////////////////
	// Registers

	logic [PRESCALE_W-1:0] prescale;
	logic tick;
	modeNibble_t mode0;
	modeNibble_t mode1;
	logic [1:0] runBit;
	logic [1:0] toggleEnable;
	logic [DATA_W-1:0] lowByte0;
	logic [DATA_W-1:0] highByte0;
	logic [DATA_W-1:0] lowByte1;
	logic [DATA_W-1:0] highByte1;
	logic [1:0] pinSample;
	logic [1:0] edgeHit;

	stepResult_t step0;
	stepResult_t step1;
	logic split;
	logic en0;
	logic en1;
	logic enHigh0;
	logic ovf0;
	logic ovf1;
	logic ovfHigh0;
	logic [1:0] ovfSet;
	logic [1:0] toggleOvf;
	logic wrCtrl;
	logic wrMode;
	logic wrPort;
	logic wrLow0;
	logic wrHigh0;
	logic wrLow1;
	logic wrHigh1;

	////////////////////////////////////////////////////////////////////////
	// Functions

	// One count step of a timer in the given mode
	function automatic stepResult_t stepCount(
		input mode_t m,
		input logic [DATA_W-1:0] lo,
		input logic [DATA_W-1:0] hi
	);
		stepResult_t r;
		logic [DATA_W+LOW13_BITS-1:0] sum13;
		logic [2*DATA_W-1:0] sum16;
		r = '{ovf: 1'b0, low: lo, high: hi};
		sum13 = {hi, lo[LOW13_BITS-1:0]} + 13'h1;
		sum16 = {hi, lo} + 16'h1;
		unique case (m)
			MODE13: begin
				r.ovf = &{hi, lo[LOW13_BITS-1:0]};
				r.low = {lo[DATA_W-1:LOW13_BITS],
					sum13[LOW13_BITS-1:0]};
				r.high = sum13[DATA_W+LOW13_BITS-1:LOW13_BITS];
			end
			MODE16: begin
				r.ovf = &{hi, lo};
				r.high = sum16[2*DATA_W-1:DATA_W];
				r.low = sum16[DATA_W-1:0];
			end
			RELOAD8: begin
				r.ovf = &lo;
				r.low = r.ovf ? hi : lo + 8'h1;
			end
			SPLIT8: begin
				r.ovf = &lo;
				r.low = lo + 8'h1;
			end
		endcase
		return r;
	endfunction : stepCount

	// Write strobe aimed at one register
	function automatic logic wrHit(
		input logic wr,
		input logic [ADDR_W-1:0] addr,
		input logic [ADDR_W-1:0] ofs
	);
		return wr && (addr == ofs);
	endfunction : wrHit

	// Register read multiplexer
	function automatic logic [DATA_W-1:0] readMux(
		input logic [ADDR_W-1:0] a
	);
		logic [DATA_W-1:0] d;
		d = RESET_BYTE;
		unique case (a)
			OFS_MODE: d = {mode1, mode0};
			OFS_CTRL: begin
				d[CTRL_OVF1_BIT] = overflowFlag[1];
				d[CTRL_RUN1_BIT] = runBit[1];
				d[CTRL_OVF0_BIT] = overflowFlag[0];
				d[CTRL_RUN0_BIT] = runBit[0];
			end
			OFS_LOW0: d = lowByte0;
			OFS_HIGH0: d = highByte0;
			OFS_LOW1: d = lowByte1;
			OFS_HIGH1: d = highByte1;
			OFS_PORTMODE: begin
				d[PM_TOGGLE0_BIT] = toggleEnable[0];
				d[PM_TOGGLE1_BIT] = toggleEnable[1];
			end
			default: d = RESET_BYTE;
		endcase
		return d;
	endfunction : readMux

	////////////////////////////////////////////////////////////////////////
	// Machine cycle prescaler

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			prescale <= '0;
		end else if (prescale == PRESCALE_LAST) begin
			prescale <= '0;
		end else begin
			prescale <= prescale + 3'h1;
		end
	end

	assign tick = (prescale == PRESCALE_LAST);

	////////////////////////////////////////////////////////////////////////
	// Count pin fall detection, one per timer

	// Starts low, so a pin held low at reset is no fall
	for (genvar i = 0; i < 2; i++) begin : gEdge
		always_ff @(posedge sys_clk or negedge reset_n) begin
			if (!reset_n) begin
				pinSample[i] <= 1'b0;
				edgeHit[i] <= 1'b0;
			end else if (tick) begin
				pinSample[i] <= countPinIn[i];
				edgeHit[i] <= pinSample[i] & ~countPinIn[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Count enables and overflow detection

	always_comb begin
		step0 = stepCount(mode0.mode, lowByte0, highByte0);
		step1 = stepCount(mode1.mode, lowByte1, highByte1);
		split = (mode0.mode == SPLIT8);
		en0 = tick & runBit[0] & (~mode0.gate | gatePin[0])
			& (mode0.counterSel ? edgeHit[0] : 1'b1);
		// Split mode: high byte 0 borrows timer 1 run bit and flag
		enHigh0 = tick & split & runBit[1];
		en1 = tick & (mode1.mode != SPLIT8)
			& (split ? 1'b1 : runBit[1] & (~mode1.gate | gatePin[1]))
			& (mode1.counterSel ? edgeHit[1] : 1'b1);
	end

	always_comb begin
		ovf0 = en0 & step0.ovf;
		ovf1 = en1 & step1.ovf;
		ovfHigh0 = enHigh0 & (&highByte0);
		ovfSet[0] = ovf0;
		ovfSet[1] = split ? ovfHigh0 : ovf1;
		toggleOvf[0] = ovf0;
		toggleOvf[1] = ovf1;
	end

	////////////////////////////////////////////////////////////////////////
	// Register write decode

	always_comb begin
		wrMode = wrHit(regWr, regAddr, OFS_MODE);
		wrCtrl = wrHit(regWr, regAddr, OFS_CTRL);
		wrPort = wrHit(regWr, regAddr, OFS_PORTMODE);
		wrLow0 = wrHit(regWr, regAddr, OFS_LOW0);
		wrHigh0 = wrHit(regWr, regAddr, OFS_HIGH0);
		wrLow1 = wrHit(regWr, regAddr, OFS_LOW1);
		wrHigh1 = wrHit(regWr, regAddr, OFS_HIGH1);
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration registers

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			mode0 <= modeNibble_t'(RESET_BYTE[NIBBLE_W-1:0]);
			mode1 <= modeNibble_t'(RESET_BYTE[NIBBLE_W-1:0]);
		end else if (wrMode) begin
			mode1 <= regWdata[MODE_T1_LSB+:NIBBLE_W];
			mode0 <= regWdata[MODE_T0_LSB+:NIBBLE_W];
		end
	end

	// Run writes never touch the count bytes
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			runBit <= '0;
		end else if (wrCtrl) begin
			runBit[1] <= regWdata[CTRL_RUN1_BIT];
			runBit[0] <= regWdata[CTRL_RUN0_BIT];
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			toggleEnable <= '0;
		end else if (wrPort) begin
			toggleEnable[0] <= regWdata[PM_TOGGLE0_BIT];
			toggleEnable[1] <= regWdata[PM_TOGGLE1_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Timer 0 count bytes
	// Software writes win over a coincident increment

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			lowByte0 <= RESET_BYTE;
		end else if (wrLow0) begin
			lowByte0 <= regWdata;
		end else if (en0) begin
			lowByte0 <= step0.low;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			highByte0 <= RESET_BYTE;
		end else if (wrHigh0) begin
			highByte0 <= regWdata;
		end else if (enHigh0) begin
			highByte0 <= highByte0 + 8'h1;
		end else if (en0 && !split) begin
			highByte0 <= step0.high;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Timer 1 count bytes

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			lowByte1 <= RESET_BYTE;
		end else if (wrLow1) begin
			lowByte1 <= regWdata;
		end else if (en1) begin
			lowByte1 <= step1.low;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			highByte1 <= RESET_BYTE;
		end else if (wrHigh1) begin
			highByte1 <= regWdata;
		end else if (en1) begin
			highByte1 <= step1.high;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Overflow flags: a hardware set wins over any clear

	for (genvar i = 0; i < 2; i++) begin : gFlag
		localparam int FLAG_BIT = (i == 0) ? CTRL_OVF0_BIT : CTRL_OVF1_BIT;
		always_ff @(posedge sys_clk or negedge reset_n) begin
			if (!reset_n) begin
				overflowFlag[i] <= 1'b0;
			end else if (ovfSet[i]) begin
				overflowFlag[i] <= 1'b1;
			end else if (wrCtrl) begin
				overflowFlag[i] <= regWdata[FLAG_BIT];
			end else if (overflowServiced[i]) begin
				overflowFlag[i] <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Toggle outputs on the count pins

	for (genvar i = 0; i < 2; i++) begin : gToggle
		always_ff @(posedge sys_clk or negedge reset_n) begin
			if (!reset_n) begin
				countPinOeN[i] <= 1'b1;
			end else begin
				countPinOeN[i] <= ~toggleEnable[i];
			end
		end

		// Pin parks high while its toggle is off
		always_ff @(posedge sys_clk or negedge reset_n) begin
			if (!reset_n) begin
				countPinOut[i] <= 1'b1;
			end else if (!toggleEnable[i]) begin
				countPinOut[i] <= 1'b1;
			end else if (toggleOvf[i]) begin
				countPinOut[i] <= ~countPinOut[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Baud source and read data

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			baudTick <= 1'b0;
		end else begin
			// Timer 1 overflow, also while timer 0 is split
			baudTick <= ovf1;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			regRdata <= RESET_BYTE;
		end else if (regRd) begin
			regRdata <= readMux(regAddr);
		end else begin
			regRdata <= RESET_BYTE;
		end
	end

endmodule : dual_timer_counter_toggle

`default_nettype wire

/* File: dual_timer_counter_toggle_props.sv */
// Port checker of the dual timer/counter.
// Assumes the prescaler restarts at zero on reset release.
`timescale 1ns/1ps
`default_nettype none
module timer_checker
	import timer_pkg::*;
(
	input wire logic sys_clk, // Clock
	input wire logic reset_n, // Reset
	input wire logic [ADDR_W-1:0] regAddr, // Address
	input wire logic [DATA_W-1:0] regWdata, // Data in
	input wire logic regWr, // Write
	input wire logic regRd, // Read
	input wire logic [DATA_W-1:0] regRdata, // Data out
	input wire logic [1:0] countPinOut, // Toggles
	input wire logic [1:0] countPinOeN, // Enables
	input wire logic [1:0] overflowServiced, // Service
	input wire logic [1:0] overflowFlag, // Flags
	input wire logic baudTick // Baud
);
	logic [PRESCALE_W-1:0] ph;
	logic tick;
	assign tick = ph == PRESCALE_LAST;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			ph <= '0;
		else
			ph <= tick ? '0 : ph + 3'h1;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////
	a_rd_idle: assert property (!$past(regRd) |-> regRdata == 8'h00)
		else $error("read data not idle");
	a_unmapped_zero: assert property ($past(regRd) && $past(regAddr) == 3'h7
		|-> regRdata == 8'h00) else $error("unmapped read not zero");
	a_flag_tick: assert property ($rose(overflowFlag[0]) |-> $past(tick)
		|| $past(regWr && regAddr == OFS_CTRL && regWdata[CTRL_OVF0_BIT]))
		else $error("flag rose off tick");
	a_flag_clear: assert property (regWr && regAddr == OFS_CTRL && !tick
		&& !regWdata[CTRL_OVF0_BIT] |=> !overflowFlag[0])
		else $error("flag not cleared by write");
	a_serv_clear: assert property (overflowServiced[0] && !tick && !regWr
		|=> !overflowFlag[0]) else $error("flag not cleared by service");
	a_idle_high: assert property ((countPinOut | ~countPinOeN) == 2'b11)
		else $error("released pin not high");
	a_toggle_tick: assert property ($changed(countPinOut[1])
		&& $stable(countPinOeN[1]) |-> $past(tick)) else $error("toggle off tick");
	a_baud_phase: assert property (baudTick |-> $past(tick))
		else $error("baud pulse off phase");
endmodule : timer_checker
bind dual_timer_counter_toggle timer_checker u_chk (.sys_clk, .reset_n,
	.regAddr, .regWdata, .regWr, .regRd, .regRdata, .countPinOut,
	.countPinOeN, .overflowServiced, .overflowFlag, .baudTick);
`default_nettype wire

/* File: count_pin_model.sv */
// Far-side model of the count and gate pins.
// Assumes the bench requests levels; block enables are active low.
`timescale 1ns/1ps
`default_nettype none
module count_pin_model (
	input wire logic sys_clk, // Clock
	input wire logic reset_n, // Reset
	input wire logic [1:0] pinReq, // Wanted levels
	input wire logic [1:0] gateReq, // Wanted gates
	input wire logic [1:0] countPinOut, // Block drive
	input wire logic [1:0] countPinOeN, // Block enable
	output logic [1:0] countPinIn, // Resolved pins
	output logic [1:0] gatePin // Gate pins
);
	logic [1:0] lvl;
	logic [2:0] held;
	// Each level stands a full machine cycle
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			lvl <= 2'b11;
			held <= 3'h0;
		end else if (pinReq != lvl && held >= 3'h5) begin
			lvl <= pinReq;
			held <= 3'h0;
		end else if (held < 3'h5)
			held <= held + 3'h1;
	end
	assign countPinIn = (countPinOeN & lvl) | (~countPinOeN & countPinOut);
	assign gatePin = gateReq;
endmodule : count_pin_model
`default_nettype wire

/* File: test_dual_timer_counter_toggle.sv */
// Self-checking bench of the dual timer/counter.
// Assumes the pin model and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
module test_dual_timer_counter_toggle;
	import timer_pkg::*;
	logic sys_clk = 1'b0, reset_n = 1'b0, regWr = 1'b0, regRd = 1'b0;
	logic [ADDR_W-1:0] regAddr = '0;
	logic [DATA_W-1:0] regWdata = '0, regRdata;
	logic [1:0] pinReq = 2'b11, gateReq = 2'b11, overflowServiced = 2'b00;
	logic [1:0] countPinIn, countPinOut, countPinOeN, gatePin, overflowFlag;
	logic [1:0] lastF = 2'b00;
	logic baudTick, lastP = 1'b1;
	int badCount = 0, nTests = 0, cyc = 0, nF0 = 0, nF1 = 0, nB = 0, nT = 0;
	dual_timer_counter_toggle DUT (.sys_clk(sys_clk), .reset_n(reset_n),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata), .countPinIn(countPinIn),
		.countPinOut(countPinOut), .countPinOeN(countPinOeN),
		.gatePin(gatePin), .overflowServiced(overflowServiced),
		.overflowFlag(overflowFlag), .baudTick(baudTick));
	count_pin_model u_pins (.sys_clk(sys_clk), .reset_n(reset_n),
		.pinReq(pinReq), .gateReq(gateReq), .countPinOut(countPinOut),
		.countPinOeN(countPinOeN), .countPinIn(countPinIn), .gatePin(gatePin));
	initial forever #12.5 sys_clk = ~sys_clk;
	////////////////////////////////////////
	// Event counters and run limit
	always @(posedge sys_clk) begin
		lastF <= overflowFlag;
		lastP <= countPinOut[1];
		nF0 <= nF0 + int'(overflowFlag[0] & ~lastF[0]);
		nF1 <= nF1 + int'(overflowFlag[1] & ~lastF[1]);
		nB <= nB + int'(baudTick);
		nT <= nT + int'(countPinOut[1] != lastP);
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			badCount++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", nTests, badCount);
		if (badCount == 0 && nTests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		nTests++;
		if (g !== e) begin
			badCount++;
			$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge sys_clk);
		regWr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge sys_clk);
		regRd <= 1'b0;
		#1 chk(16'(regRdata), 16'(e));
	endtask : rd
	// Runs for exactly two machine ticks, then checks bytes and events
	task automatic run12(input logic [7:0] md, input logic [2:0] la,
		input logic [7:0] lo, hi, input logic [2:0] ra,
		input logic [7:0] on, off, elo, ehi, input logic [15:0] ev);
		int a0, a1, a2, a3;
		wr(OFS_MODE, md);
		wr(la, lo);
		wr(la + 3'h1, hi);
		a0 = nF0;
		a1 = nF1;
		a2 = nB;
		a3 = nT;
		wr(ra, on);
		repeat (10) @(posedge sys_clk);
		wr(ra, off);
		rd(la, elo);
		rd(la + 3'h1, ehi);
		chk({4'(nF0 - a0), 4'(nF1 - a1), 4'(nB - a2), 4'(nT - a3)}, ev);
	endtask : run12
	////////////////////////////////////////
	task automatic t_modes();
		run12(8'h00, OFS_LOW0, 8'hff, 8'hff, OFS_CTRL, 8'h10, 8'h00, 8'he1, 8'h00, 16'h1000);
		run12(8'h01, OFS_LOW0, 8'hff, 8'hff, OFS_CTRL, 8'h10, 8'h00, 8'h01, 8'h00, 16'h1000);
		run12(8'h02, OFS_LOW0, 8'hff, 8'hf0, OFS_CTRL, 8'h10, 8'h00, 8'hf1, 8'hf0, 16'h1000);
		gateReq[1] <= 1'b0;
		run12(8'h80, OFS_LOW1, 8'h00, 8'h00, OFS_CTRL, 8'h40, 8'h00, 8'h00, 8'h00, 16'h0000);
		gateReq[1] <= 1'b1;
		$display("timer modes done");
	endtask : t_modes
	task automatic t_toggle();
		wr(OFS_PORTMODE, 8'h02);
		@(posedge sys_clk);
		#1 chk(16'(countPinOeN), 16'h0001);
		chk(16'(countPinOut), 16'h0003);
		run12(8'h20, OFS_LOW1, 8'hff, 8'hff, OFS_CTRL, 8'h40, 8'h00, 8'hff, 8'hff, 16'h0122);
		run12(8'h33, OFS_LOW0, 8'hff, 8'hff, OFS_CTRL, 8'h40, 8'h00, 8'hff, 8'h01, 16'h0100);
		run12(8'h31, OFS_LOW1, 8'h00, 8'h00, OFS_CTRL, 8'h40, 8'h00, 8'h00, 8'h00, 16'h0000);
		run12(8'h33, OFS_LOW1, 8'hff, 8'hff, OFS_MODE, 8'h13, 8'h33, 8'h01, 8'h00, 16'h0011);
		$display("toggle and split done");
	endtask : t_toggle
	task automatic t_counter();
		wr(OFS_MODE, 8'h0d);
		wr(OFS_LOW0, 8'hfe);
		wr(OFS_HIGH0, 8'hff);
		wr(OFS_CTRL, 8'h10);
		repeat (3) begin
			pinReq[0] <= 1'b0;
			repeat (12) @(posedge sys_clk);
			pinReq[0] <= 1'b1;
			repeat (12) @(posedge sys_clk);
		end
		gateReq[0] <= 1'b0;
		rd(OFS_LOW0, 8'h01);
		rd(OFS_CTRL, 8'h30);
		repeat (12) @(posedge sys_clk);
		rd(OFS_LOW0, 8'h01);
		rd(3'h7, 8'h00);
		@(posedge sys_clk);
		overflowServiced[0] <= 1'b1;
		@(posedge sys_clk);
		overflowServiced[0] <= 1'b0;
		@(posedge sys_clk);
		#1 chk(16'(overflowFlag), 16'h0000);
		$display("counter done");
	endtask : t_counter
	initial begin
		repeat (4) @(posedge sys_clk);
		reset_n <= 1'b1;
		t_modes();
		t_toggle();
		t_counter();
		stop_test();
	end
endmodule : test_dual_timer_counter_toggle
`default_nettype wire
